// ---- rtl/adcc_ctrl.sv ----
// conversion, power-down, sequencer, selection and code format control
// Summary of operation
// - falling strobe starts conversion, internally timed
// - strobe high floats serial output
// - strobe low and powered drives serial output
// - power-down aborts conversion, output floats
// - stay powered down until pin returns high
// - normal mode: first sample after wake invalid
// - low-power mode: first sample valid, same selection
// - power-down pin defaults inactive high
// - low-power needs one sample with pin high
// - low-power pin defaults low, normal mode
// - sequencer starts input_0 at next rising strobe
// - sequencer steps one input per rising strobe
// - sequencer ignores channel select pins
// - sequencer off: channel from select pins
// - floating gain pin bypasses amplifier
// - gain may change with setup and hold
// - bipolar mode gives two's complement codes
// - bipolar gain two or more: full 14-bit
// - bipolar gain one or bypass: 13-bit span
// - unipolar gives unsigned 13-bit codes
// - normal applies selection next sample, low-power same
// - sequencer wraps input_7 back to input_0
// - saturate bipolar high gain; unipolar clamp zero
// - eight gain settings from three pins
`include "adcc_cfg.svh"
`default_nettype none
module adcc_ctrl #(
    parameter int CONV_CYC = `ADCC_CONV_CYC
) (
    input wire logic i_core_clk, // internal conversion clock
    input wire logic i_rst_n, // async reset, active low
    input wire logic i_link_clk, // serial readout clock
    input wire logic i_conv_start_n, // convert strobe pin
    input wire logic i_power_down_n, // power-down pin
    input wire logic i_low_power_sel, // low-power mode pin
    input wire logic i_sequence_enable, // scan enable pin
    input wire logic i_chan_sel_2, // channel select msb
    input wire logic i_chan_sel_1, // channel select
    input wire logic i_chan_sel_0, // channel select lsb
    input wire logic i_gain_sel_2_or_bypass, // gain msb level
    input wire logic i_gain_bypass_float, // gain msb pin sensed floating
    input wire logic i_gain_sel_1, // gain select
    input wire logic i_gain_sel_0, // gain select lsb
    input wire logic i_polarity_float, // polarity pin floating: bipolar
    input wire logic signed [15:0] i_conv_code, // raw converter result
    output logic [2:0] o_active_chan, // channel used by conversion
    output logic [2:0] o_active_gain, // gain code used
    output logic o_pga_bypass, // amplifier bypassed
    output logic o_converting, // conversion running
    output logic o_powered_down, // in power-down
    output logic o_data_valid, // last result valid
    output logic [13:0] o_result_code, // last formatted code
    output logic o_serial_data_out, // serial data, link domain
    output logic o_serial_data_out_oe // serial driver enable
);
    import adcc_pkg::*;

    // elaboration check: counter is 12 bits wide
    if (CONV_CYC < 2 || CONV_CYC > 4096) begin : g_conv_cyc_bad
        $error("CONV_CYC out of range");
    end

    localparam logic [11:0] CONV_LAST = 12'(CONV_CYC - 1);

    // pin synchronisers, change taken when stages 2 and 3 agree
    logic [`ADCC_PIN_W-1:0] pins;
    logic [`ADCC_PIN_W-1:0] s1_q, s2_q, s3_q, pf_q, pf_d;
    assign pins = {i_conv_start_n, i_power_down_n, i_low_power_sel, i_sequence_enable,
                   i_chan_sel_2, i_chan_sel_1, i_chan_sel_0,
                   i_gain_sel_2_or_bypass, i_gain_sel_1, i_gain_sel_0,
                   i_gain_bypass_float, i_polarity_float};

    always_comb begin
        for (int i = 0; i < `ADCC_PIN_W; i++) begin
            pf_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : pf_q[i];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_q <= `ADCC_PIN_RST;
            s2_q <= `ADCC_PIN_RST;
            s3_q <= `ADCC_PIN_RST;
            pf_q <= `ADCC_PIN_RST;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pf_q <= pf_d;
        end
    end

    logic cs_n, pd_n, low_power_sel, seq_en, byp, bip;
    logic [2:0] chan_pin, gain_pin;
    assign cs_n = pf_q[`ADCC_P_CS];
    assign pd_n = pf_q[`ADCC_P_PD];
    assign low_power_sel = pf_q[`ADCC_P_LPM];
    assign seq_en = pf_q[`ADCC_P_SEQ];
    assign chan_pin = pf_q[`ADCC_P_CH_HI:`ADCC_P_CH_LO];
    assign gain_pin = pf_q[`ADCC_P_G_HI:`ADCC_P_G_LO];
    assign byp = pf_q[`ADCC_P_BYP];
    assign bip = pf_q[`ADCC_P_BIP];

    // core control state
    adcc_state_type st_q, st_d;
    logic [11:0] cnt_q, cnt_d;
    logic cs_prev_q, cs_prev_d, seq_on_q, seq_on_d, skip_q, skip_d;
    logic arm_q, arm_d, valid_q, valid_d, tgl_q, tgl_d, oe_q, oe_d;
    logic [2:0] seq_ch_q, seq_ch_d, lat_ch_q, lat_ch_d, app_ch_q, app_ch_d;
    logic [2:0] lat_g_q, lat_g_d, app_g_q, app_g_d, cv_ch_q, cv_ch_d, cv_g_q, cv_g_d;
    logic lat_b_q, lat_b_d, app_b_q, app_b_d, cv_b_q, cv_b_d;
    logic [`ADCC_WORD_W-1:0] word_q, word_d;
    logic cs_rise, cs_fall, lpm_now, high_gain;
    logic [2:0] sel_ch;
    logic [13:0] code;

    assign cs_rise = cs_n && !cs_prev_q;
    assign cs_fall = !cs_n && cs_prev_q;
    assign lpm_now = low_power_sel && arm_q;
    assign sel_ch = seq_en ? (seq_on_q ? 3'(seq_ch_q + 3'h1) : 3'h0) : chan_pin;
    assign high_gain = !cv_b_q && (cv_g_q != `ADCC_GAIN_UNITY);

    // output code format
    always_comb begin
        code = i_conv_code[13:0];
        if (bip && high_gain) begin
            if (i_conv_code > `ADCC_BIP_MAX) begin
                code = 14'(`ADCC_BIP_MAX);
            end else if (i_conv_code < `ADCC_BIP_MIN) begin
                code = 14'(`ADCC_BIP_MIN);
            end
        end else if (!bip && i_conv_code < `ADCC_UNI_MIN) begin
            code = 14'h0000;
        end
    end

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        cs_prev_d = cs_n;
        seq_on_d = seq_on_q;
        seq_ch_d = seq_ch_q;
        skip_d = skip_q;
        arm_d = arm_q;
        valid_d = valid_q;
        tgl_d = tgl_q;
        lat_ch_d = lat_ch_q;
        lat_g_d = lat_g_q;
        lat_b_d = lat_b_q;
        app_ch_d = app_ch_q;
        app_g_d = app_g_q;
        app_b_d = app_b_q;
        cv_ch_d = cv_ch_q;
        cv_g_d = cv_g_q;
        cv_b_d = cv_b_q;
        word_d = word_q;
        oe_d = !cs_n && pd_n;
        if (cs_rise) begin
            seq_on_d = seq_en;
            if (seq_en) begin
                seq_ch_d = sel_ch;
            end
            lat_ch_d = sel_ch;
            lat_g_d = gain_pin;
            lat_b_d = byp;
            if (lpm_now) begin
                app_ch_d = sel_ch;
                app_g_d = gain_pin;
                app_b_d = byp;
            end else begin
                app_ch_d = lat_ch_q;
                app_g_d = lat_g_q;
                app_b_d = lat_b_q;
            end
            if (low_power_sel && st_q != ST_PWRDN) begin
                arm_d = 1'b1;
            end
        end
        unique case (st_q)
            ST_PWRDN: begin
                if (pd_n) begin
                    st_d = ST_IDLE;
                    skip_d = !lpm_now;
                end
            end
            ST_IDLE: begin
                if (!pd_n) begin
                    st_d = ST_PWRDN;
                end else if (cs_fall) begin
                    st_d = ST_CONV;
                    cnt_d = CONV_LAST;
                    cv_ch_d = app_ch_q;
                    cv_g_d = app_g_q;
                    cv_b_d = app_b_q;
                end
            end
            ST_CONV: begin
                if (!pd_n) begin
                    st_d = ST_PWRDN;
                    valid_d = 1'b0;
                end else if (cnt_q == 12'h000) begin
                    st_d = ST_IDLE;
                    skip_d = 1'b0;
                    valid_d = !skip_q;
                    if (!skip_q) begin
                        word_d = {code, cv_ch_q, cv_g_q};
                        tgl_d = !tgl_q;
                    end
                end else begin
                    cnt_d = 12'(cnt_q - 12'h001);
                end
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= ST_PWRDN;
            cnt_q <= 12'h000;
            cs_prev_q <= 1'b0;
            seq_on_q <= 1'b0;
            seq_ch_q <= 3'h0;
            skip_q <= 1'b1;
            arm_q <= 1'b0;
            valid_q <= 1'b0;
            tgl_q <= 1'b0;
            lat_ch_q <= 3'h0;
            lat_g_q <= 3'h0;
            lat_b_q <= 1'b0;
            app_ch_q <= 3'h0;
            app_g_q <= 3'h0;
            app_b_q <= 1'b0;
            cv_ch_q <= 3'h0;
            cv_g_q <= 3'h0;
            cv_b_q <= 1'b0;
            word_q <= 20'h00000;
            oe_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            cs_prev_q <= cs_prev_d;
            seq_on_q <= seq_on_d;
            seq_ch_q <= seq_ch_d;
            skip_q <= skip_d;
            arm_q <= arm_d;
            valid_q <= valid_d;
            tgl_q <= tgl_d;
            lat_ch_q <= lat_ch_d;
            lat_g_q <= lat_g_d;
            lat_b_q <= lat_b_d;
            app_ch_q <= app_ch_d;
            app_g_q <= app_g_d;
            app_b_q <= app_b_d;
            cv_ch_q <= cv_ch_d;
            cv_g_q <= cv_g_d;
            cv_b_q <= cv_b_d;
            word_q <= word_d;
            oe_q <= oe_d;
        end
    end

    // link side: toggle crossing, word held stable, then shifted msb first
    logic [2:0] lt_q;
    logic ltf_q, ltf_d, load;
    logic [`ADCC_WORD_W-1:0] sh_q, sh_d;
    assign load = (lt_q[2] == lt_q[1]) && (lt_q[2] != ltf_q);

    always_comb begin
        ltf_d = ltf_q;
        sh_d = {sh_q[`ADCC_WORD_W-2:0], 1'b0};
        if (load) begin
            ltf_d = lt_q[2];
            sh_d = word_q;
        end
    end

    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lt_q <= 3'h0;
            ltf_q <= 1'b0;
            sh_q <= 20'h00000;
        end else begin
            lt_q <= {lt_q[1:0], tgl_q};
            ltf_q <= ltf_d;
            sh_q <= sh_d;
        end
    end

    assign o_serial_data_out = sh_q[`ADCC_WORD_W-1];
    assign o_serial_data_out_oe = oe_q;
    assign o_active_chan = cv_ch_q;
    assign o_active_gain = cv_g_q;
    assign o_pga_bypass = cv_b_q;
    assign o_converting = (st_q == ST_CONV);
    assign o_powered_down = (st_q == ST_PWRDN);
    assign o_data_valid = valid_q;
    assign o_result_code = word_q[`ADCC_WORD_W-1:6];

    // checks
    sequence s_rise_scan;
        cs_rise && seq_en;
    endsequence

    sequence s_conv_done;
        st_q == ST_CONV && pd_n && cnt_q == 12'h000 && !skip_q;
    endsequence

    a_sdo_float: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        cs_n |=> !o_serial_data_out_oe) else $error("serial output driven while strobe high");
    a_sdo_drive: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        !cs_n && pd_n |=> o_serial_data_out_oe) else $error("serial output not driven");
    a_pd_abort: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        st_q == ST_CONV && !pd_n |=> st_q == ST_PWRDN && !o_serial_data_out_oe && !valid_q)
        else $error("power-down did not abort");
    a_pd_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        st_q == ST_PWRDN && !pd_n |=> st_q == ST_PWRDN) else $error("left power-down early");
    a_conv_start: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        st_q == ST_IDLE && pd_n && cs_fall |=> st_q == ST_CONV && cnt_q == CONV_LAST)
        else $error("conversion did not start");
    a_seq_first: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_rise_scan ##0 !seq_on_q |=> seq_ch_q == 3'h0 && lat_ch_q == 3'h0)
        else $error("scan did not begin at input_0");
    a_seq_step: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_rise_scan ##0 seq_on_q |=> seq_ch_q == 3'($past(seq_ch_q) + 3'h1))
        else $error("scan step wrong");
    a_chan_pins: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        cs_rise && !seq_en |=> lat_ch_q == $past(chan_pin)) else $error("pin channel not taken");
    a_wake_skip: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        st_q == ST_PWRDN && pd_n && !low_power_sel |=> skip_q && st_q == ST_IDLE)
        else $error("first sample after wake not discarded");
    a_lpm_same: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        cs_rise && lpm_now |=> app_ch_q == $past(sel_ch)) else $error("low-power selection late");
    a_bip_clamp: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_conv_done ##0 bip && high_gain && i_conv_code > `ADCC_BIP_MAX
        |=> o_result_code == 14'h1FFF && o_data_valid) else $error("bipolar clamp failed");
    a_uni_zero: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_conv_done ##0 !bip && i_conv_code < `ADCC_UNI_MIN
        |=> o_result_code == 14'h0000) else $error("unipolar zero clamp failed");
endmodule
`default_nettype wire

// ---- rtl/adcc_cfg.svh ----
// constants for the converter control block
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

// core clock period and conversion time
`define ADCC_CLK_NS 20
`define ADCC_T_CONV_NS 1000
`define ADCC_CONV_CYC ((`ADCC_T_CONV_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)

// output code limits
`define ADCC_BIP_MAX 16'sh1FFF
`define ADCC_BIP_MIN 16'shE000
`define ADCC_UNI_MIN 16'sh0000

// gain code meaning unity gain
`define ADCC_GAIN_UNITY 3'h0

// pin vector field positions
`define ADCC_P_CS 11
`define ADCC_P_PD 10
`define ADCC_P_LPM 9
`define ADCC_P_SEQ 8
`define ADCC_P_CH_HI 7
`define ADCC_P_CH_LO 5
`define ADCC_P_G_HI 4
`define ADCC_P_G_LO 2
`define ADCC_P_BYP 1
`define ADCC_P_BIP 0
`define ADCC_PIN_W 12

// pin reset values: strobe low, power-down released, normal mode
`define ADCC_PIN_RST 12'h400

// serial word: code, channel, gain
`define ADCC_WORD_W 20

`endif

// ---- rtl/adcc_pkg.sv ----
// types for the converter control block
`default_nettype none
package adcc_pkg;
    typedef enum logic [2:0] {
        ST_PWRDN = 3'b001,
        ST_IDLE = 3'b010,
        ST_CONV = 3'b100
    } adcc_state_type;
endpackage
`default_nettype wire

// ---- verif/adcc_host.sv ----
// host model: convert strobe, power-down pin and framed serial readout
`default_nettype none
module adcc_host #(
    parameter int CONV_CYC = 4
) (
    input wire logic i_core_clk, // core clock
    input wire logic i_converting, // device busy
    input wire logic i_serial_data_out, // serial data
    input wire logic i_serial_data_out_oe, // serial driver enable
    output logic o_conv_start_n, // convert strobe
    output logic o_power_down_n, // power-down pin
    output logic o_link_clk // readout clock, four pulses at start, then runs in frames only
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic link_pulse();
        #16 o_link_clk = 1'b1;
        #16 o_link_clk = 1'b0;
    endtask
    initial begin
        o_conv_start_n = 1'b0;
        o_power_down_n = 1'b1;
        o_link_clk = 1'b0;
        #7;
        repeat (4) link_pulse();
    end
    task automatic set_pd(input logic v);
        @(posedge i_core_clk) o_power_down_n <= v;
        repeat (6) @(posedge i_core_clk);
    endtask
    // rise latches selection, fall starts conversion, strobe then stays low
    task automatic sample(input logic abort, output logic ok, output logic oe_hi,
                          output logic oe_lo, output logic [39:0] bits);
        int n;
        bits = '0;
        @(posedge i_core_clk) o_conv_start_n <= 1'b1;
        repeat (6) @(posedge i_core_clk);
        oe_hi = i_serial_data_out_oe;
        @(posedge i_core_clk) o_conv_start_n <= 1'b0;
        n = 0;
        while (i_converting !== 1'b1 && n < 20) begin
            @(posedge i_core_clk);
            n++;
        end
        ok = (n < 20);
        oe_lo = i_serial_data_out_oe;
        if (abort) o_power_down_n <= 1'b0;
        n = 0;
        while (i_converting !== 1'b0 && n < CONV_CYC + 12) begin
            @(posedge i_core_clk);
            n++;
        end
        ok = ok && (n < CONV_CYC + 12);
        repeat (3) @(posedge i_core_clk);
        if (abort) begin
            oe_lo = i_serial_data_out_oe;
        end else begin
            #3;
            repeat (30) begin
                link_pulse();
                // released line reads as the inverse of the last bit
                bits = {bits[38:0], i_serial_data_out_oe ? i_serial_data_out : !i_serial_data_out};
            end
        end
    endtask
endmodule
`default_nettype wire

// ---- verif/adcc_ctrl_tb_top.sv ----
// self-checking testbench for the converter control block
`default_nettype none
module adcc_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import adcc_pkg::*;
    localparam int CONV = 12;
    logic core_clk = 1'b0, rst_n = 1'b0, low_power_sel = 1'b0, seq = 1'b0, byp = 1'b0, bip = 1'b1;
    logic [2:0] ch = 3'h5, gain = 3'h0, act_ch, act_g;
    logic signed [15:0] code = 16'sh0000;
    logic conv_n, pd_n, link_clk, pga_byp, converting, pdown, valid, serial_data_out, sdo_oe;
    logic ok, oe_hi, oe_lo;
    logic [39:0] bits;
    logic [13:0] res;
    int errors = 0, n_compared = 0;
    logic [15:0] raws [8] = '{16'h2328, 16'h2328, 16'hDCD8, 16'hFF9C,
                              16'hFFFB, 16'h2134, 16'h1FFF, 16'h0FFF};
    always #10 core_clk = ~core_clk;
    adcc_ctrl #(.CONV_CYC(CONV)) i_adcc_ctrl (.i_core_clk(core_clk), .i_rst_n(rst_n),
        .i_link_clk(link_clk), .i_conv_start_n(conv_n), .i_power_down_n(pd_n),
        .i_low_power_sel(low_power_sel), .i_sequence_enable(seq), .i_chan_sel_2(ch[2]),
        .i_chan_sel_1(ch[1]), .i_chan_sel_0(ch[0]), .i_gain_sel_2_or_bypass(gain[2]),
        .i_gain_bypass_float(byp), .i_gain_sel_1(gain[1]), .i_gain_sel_0(gain[0]),
        .i_polarity_float(bip), .i_conv_code(code), .o_active_chan(act_ch),
        .o_active_gain(act_g), .o_pga_bypass(pga_byp), .o_converting(converting),
        .o_powered_down(pdown), .o_data_valid(valid), .o_result_code(res),
        .o_serial_data_out(serial_data_out), .o_serial_data_out_oe(sdo_oe));
    adcc_host #(.CONV_CYC(CONV)) i_adcc_host (.i_core_clk(core_clk), .i_converting(converting),
        .i_serial_data_out(serial_data_out), .i_serial_data_out_oe(sdo_oe), .o_conv_start_n(conv_n),
        .o_power_down_n(pd_n), .o_link_clk(link_clk));
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic cmp_word(input logic [16:0] exp, input string msg);
        logic hit;
        hit = 1'b0;
        for (int s = 0; s <= 23; s++) if (bits[s +: 17] === exp) hit = 1'b1;
        cmp_val({15'h0, hit}, 16'h0001, msg);
    endtask
    task automatic run(input logic abort, input logic exp_ok);
        i_adcc_host.sample(abort, ok, oe_hi, oe_lo, bits);
        if (ok !== exp_ok) begin
            errors++;
            $display("mismatch at %0t: conversion wait bound used up", $time);
            complete_run();
        end
        cmp_val({15'h0, oe_hi}, 16'h0000, "driver off while strobe high");
        if (exp_ok && !abort) cmp_val({15'h0, oe_lo}, 16'h0001, "driver on");
    endtask
    function automatic logic [13:0] exp_code(input logic b, input logic y, input logic [2:0] g,
                                             input logic signed [15:0] raw);
        if (!b) return (raw < 0) ? 14'h0000 : raw[13:0];
        if (y || g == 3'h0) return raw[13:0];
        if (raw > 16'sh1FFF) return 14'h1FFF;
        if (raw < -16'sh2000) return 14'h2000;
        return raw[13:0];
    endfunction
    initial begin
        repeat (5) @(posedge core_clk);
        cmp_val({15'h0, pdown}, 16'h0001, "reset powered down");
        cmp_val({14'h0, converting, sdo_oe}, 16'h0000, "reset idle");
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        // 15 us settling before the first acquisition
        repeat (750) @(posedge core_clk);
        run(1'b0, 1'b1);
        cmp_val({15'h0, valid}, 16'h0000, "first sample after wake");
        $display("test wake done");
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            bip <= 1'(8'h4F >> i);
            byp <= 1'(8'h88 >> i);
            gain <= 3'(i);
            code <= raws[i];
            repeat (6) @(posedge core_clk);
            run(1'b0, 1'b1);
            run(1'b0, 1'b1);
            cmp_val({2'h0, res}, {2'h0, exp_code(bip, byp, 3'(i), raws[i])}, "code");
            cmp_val({15'h0, valid}, 16'h0001, "valid");
            cmp_val({13'h0, act_ch}, 16'h0005, "pin channel");
            cmp_val({15'h0, pga_byp}, {15'h0, byp}, "bypass");
            if (!byp) cmp_val({13'h0, act_g}, 16'(i), "gain code");
            cmp_word({exp_code(bip, byp, 3'(i), raws[i]), 3'h5}, "serial word");
        end
        $display("test format done");
        @(posedge core_clk);
        seq <= 1'b1;
        ch <= 3'h3;
        repeat (6) @(posedge core_clk);
        for (int k = 0; k < 10; k++) begin
            run(1'b0, 1'b1);
            if (k == 0) cmp_val({13'h0, act_ch}, 16'h0005, "scan lag");
            if (k > 0) cmp_val({13'h0, act_ch}, 16'((k - 1) % 8), "scan channel");
        end
        $display("test scan done");
        @(posedge core_clk);
        seq <= 1'b0;
        ch <= 3'h6;
        low_power_sel <= 1'b1;
        repeat (6) @(posedge core_clk);
        run(1'b0, 1'b1);
        i_adcc_host.set_pd(1'b0);
        cmp_val({15'h0, pdown}, 16'h0001, "powered down");
        run(1'b0, 1'b0);
        @(posedge core_clk);
        ch <= 3'h2;
        i_adcc_host.set_pd(1'b1);
        cmp_val({15'h0, pdown}, 16'h0000, "woken");
        run(1'b0, 1'b1);
        cmp_val({15'h0, valid}, 16'h0001, "low-power first valid");
        cmp_val({13'h0, act_ch}, 16'h0002, "same-sample channel");
        $display("test low power done");
        run(1'b1, 1'b1);
        cmp_val({13'h0, converting, pdown, valid}, 16'h0002, "abort state");
        cmp_val({15'h0, oe_lo}, 16'h0000, "driver off after abort");
        i_adcc_host.set_pd(1'b1);
        $display("test abort done");
        complete_run();
    end
endmodule
`default_nettype wire
